// ==== dv/ecnpm_card_model.sv ====
/*
 * Behavioural card slot seen through the two card chip select pins.
 * Assumes active-low selects and a wait line with a pull-up.
 */
`timescale 1ns/1ns
module ecnpm_card_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   // Card selects taken from the pins, active low
   input  wire logic       card_sel0_n_in,
   input  wire logic       card_sel1_n_in,
   // Wait cycles per access, zero answers at once
   input  wire logic [3:0] stall_cycles_in,
   // Wait toward the controller, active low
   output logic            card_wait_n_out
);
   ////////////////////////////////////////////////////////////////////
   logic [3:0] wait_cnt_r;    // Wait cycles served so far
   logic [3:0] wait_cnt_nxt;  // Next wait count
   logic       sel;           // Either slot selected
   // Card reset, interrupt and detect stay on general I/O
   // Only the card listens on these pins while its slot is enabled
   assign sel = ~card_sel0_n_in | ~card_sel1_n_in;
   // Count wait cycles while selected, restart once deselected
   always_comb begin
      wait_cnt_nxt = 4'h0;
      if (sel && wait_cnt_r != stall_cycles_in) begin
         wait_cnt_nxt = wait_cnt_r + 4'h1;
      end else if (sel) begin
         wait_cnt_nxt = wait_cnt_r;
      end
   end
   // Register the count
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wait_cnt_r <= 4'h0;
      end else begin
         wait_cnt_r <= wait_cnt_nxt;
      end
   end
   // Pull-up level as soon as the stall is served or slot released
   assign card_wait_n_out = ~(sel && wait_cnt_r < stall_cycles_in);
endmodule : ecnpm_card_model

// ==== dv/testbench.sv ====
/*
 * Self-checking bench of the card and flash pin multiplexer.
 * Assumes the design package and the card slot model are compiled.
 */
`timescale 1ns/1ns
module testbench;
   import ecnpm_pkg::*;
   ////////////////////////////////////////////////////////////////////
   logic        clk_in = 1'b0;  // 20 MHz clock
   logic        srst_in = 1'b1; // Reset, active high
   logic        s0_en = 1'b0;   // Slot enables and flash enable
   logic        s1_en = 1'b0;
   logic        nand_en = 1'b0;
   logic        act = 1'b0;     // Transfer from the controller
   logic [31:0] addr = 32'h0;
   logic        rd = 1'b0;
   logic [7:0]  cs_n = 8'hff;
   logic [3:0]  stb = 4'hf;     // Read, write0, bs1, bs3 strobes
   logic        a25 = 1'b0;
   logic [3:0]  stall = 4'h0;   // Card wait cycles
   wire         wait_n;         // Card wait line
   logic        ext_w_n, cs3, cs4, cs5, cs6, cs7;
   logic        p_oe, p_we, p_ior, p_iow, p_rnw, acc, bsel, cstr;
   logic [1:0]  bw;
   ecnpm_mode_t mode;
   logic        dir_r = 1'b0;   // Expected card direction
   logic        prev_act = 1'b0;
   ecnpm_mode_t exp_mode = 3'h0;
   int          num_errors = 0;
   int          checks = 0;
   int          i, n, s, r, k;
   logic [2:0]  modes [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
   // Clock
   always #25 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////
   ecnpm_mux i_ecnpm_mux (.clk_in(clk_in), .srst_in(srst_in),
      .card_slot0_enable_in(s0_en), .card_slot1_enable_in(s1_en),
      .nand_enable_in(nand_en), .xfer_active_in(act),
      .xfer_addr_in(addr), .xfer_read_in(rd), .ctl_cs_n_in(cs_n),
      .read_strobe_n_in(stb[3]), .write_strobe0_n_in(stb[2]),
      .write_byte_select1_n_in(stb[1]), .write_byte_select3_n_in(stb[0]),
      .ctl_a25_in(a25), .card_wait_n_in(wait_n),
      .external_wait_n_out(ext_w_n), .chip_select_three_n_out(cs3),
      .chip_select_four_n_out(cs4), .chip_select_five_n_out(cs5),
      .chip_select_six_n_out(cs6), .chip_select_seven_n_out(cs7),
      .pin_rd_oe_n_out(p_oe), .pin_wr0_we_n_out(p_we),
      .pin_bs1_ior_n_out(p_ior), .pin_bs3_iow_n_out(p_iow),
      .pin_a25_rnw_out(p_rnw), .card_mode_out(mode),
      .card_access_out(acc), .cs0_byte_select_out(bsel),
      .cs0_bus_width_out(bw), .cs0_cs_strobes_out(cstr));
   ecnpm_card_model i_ecnpm_card_model (.clk_in(clk_in),
      .srst_in(srst_in), .card_sel0_n_in(cs4), .card_sel1_n_in(cs5),
      .stall_cycles_in(stall), .card_wait_n_out(wait_n));
   ////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Counts, verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   // One bus cycle from a falling edge, pins checked a cycle later
   task automatic step(input logic a, input logic [31:0] ad,
                       input logic r, input logic [7:0] c,
                       input logic [3:0] st, input logic a5);
      logic       hit, nh, io, ide, fo, fw;
      logic [9:0] ep;
      act = a; addr = ad; rd = r; cs_n = c; stb = st; a25 = a5;
      hit = a && ((ad[31:28] == 4'h5 && s0_en) ||
                  (ad[31:28] == 4'h6 && s1_en));
      nh = a && nand_en && ad[31:28] == 4'h4 && !c[3];
      io = ad[23];
      ide = ad[23] & ad[22];
      if (hit && !prev_act) dir_r = r;
      fo = nh ? st[3] : 1'b1;
      fw = nh ? st[2] : 1'b1;
      ep[9:5] = {c[3], c[4], c[5], nand_en ? fo : c[6], nand_en ? fw : c[7]};
      // Card access swaps the shared strobes by mode
      if (hit) begin
         ep[4:0] = {io ? ~ide : st[3], io | st[2], ~io | st[3],
                    ~io | st[2], dir_r};
      end else begin
         ep[4:0] = {st, a5};
      end
      #1;
      check({15'h0, ext_w_n}, {15'h0, hit ? wait_n : 1'b1});
      prev_act = a;
      @(negedge clk_in);
      check({6'h0, cs3, cs4, cs5, cs6, cs7, p_oe, p_we, p_ior, p_iow, p_rnw},
            {6'h0, ep});
      if (hit) exp_mode = ad[23:21];
      check({12'h0, acc, mode}, {12'h0, hit, exp_mode});
   endtask : step
   // Single-cycle transfer followed by an idle cycle
   task automatic xf(input logic [31:0] ad, input logic r,
                     input logic [7:0] c, input logic [3:0] st);
      step(1'b1, ad, r, c, st, ~r);
      step(1'b0, ad, 1'b0, 8'hff, 4'hf, 1'b0);
   endtask : xf
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      srst_in = 1'b0;
      check({12'h0, bsel, bw, cstr}, {12'h0, 1'b1, 2'h1, 1'b1});
      step(1'b0, 32'h0, 1'b0, 8'hff, 4'hf, 1'b0);
      $display("test reset done");
      // Every card mode on both slots, read and write; A23 picks I/O
      s0_en = 1'b1;
      s1_en = 1'b1;
      for (s = 0; s < 2; s++) begin
         for (k = 0; k < 5; k++) begin
            for (r = 0; r < 2; r++) begin
               xf({s[0] ? 4'h6 : 4'h5, 4'h0, modes[k], 21'h0}, r[0],
                  s[0] ? 8'hdf : 8'hef, r[0] ? 4'h4 : 4'h8);
            end
         end
      end
      // Slot disabled: ordinary pins, card wait kept off the controller
      s0_en = 1'b0;
      stall = 4'h3;
      step(1'b1, 32'h5040_0000, 1'b1, 8'hef, 4'h4, 1'b0);
      xf(32'h5040_0000, 1'b1, 8'hef, 4'h4);
      $display("test card modes done");
      // Stretched read: direction flips on the bus but the pin holds
      s0_en = 1'b1;
      stall = 4'h3;
      n = 0;
      i = 0;
      do begin
         step(1'b1, 32'h5040_0000, i == 0, 8'hef, 4'h7, 1'b0);
         i++;
         if (ext_w_n === 1'b0) n++;
      end while (ext_w_n !== 1'b1 && i < 10);
      // A wait that never ends counts once; the run goes on to the verdict
      if (ext_w_n !== 1'b1) begin
         num_errors++;
      end
      check(n[15:0], {12'h0, stall});
      step(1'b0, 32'h0, 1'b0, 8'hff, 4'hf, 1'b0);
      stall = 4'h0;
      $display("test card wait done");
      // Flash chip enable and busy stay on general I/O
      // Flash: command at A22, address at A21, data, then outside space
      s0_en = 1'b0;
      s1_en = 1'b0;
      nand_en = 1'b1;
      xf(32'h4040_0000, 1'b0, 8'hf7, 4'hb);
      xf(32'h4020_0000, 1'b0, 8'hf7, 4'hb);
      xf(32'h4000_0000, 1'b1, 8'hf7, 4'h7);
      xf(32'h3000_0000, 1'b1, 8'hf7, 4'h7);
      // Chip selects six and seven return once flash is off
      nand_en = 1'b0;
      xf(32'h7000_0000, 1'b1, 8'hbf, 4'h7);
      xf(32'h8000_0000, 1'b0, 8'h7f, 4'hb);
      $display("test flash done");
      end_sim();
   end
endmodule : testbench

// ==== rtl/ecnpm_cfg.svh ====
/*
 * Constants of the card and flash pin multiplexer: address spaces,
 * mode codes and the reset defaults of chip select 0.
 * Assumes a 32-bit system bus address and active-low memory strobes.
 */
// Overview of operation
// - Slot enables put card selects on pins 4/5
// - Card access swaps shared strobes to card signals
// - Card select 0 mirrors chip select four
// - Card direction held stable whole transfer
// - Card wait stretches controller access
// - Flash logic active in 0x4 space
// - Chip select three steers strobes to flash
// - Flash strobes drop when address leaves space
// - Flash enable replaces chip selects six, seven
// - Flash words told apart by address offset
// - Chip select 0 boots 16-bit byte-select
// - Bits 23..21 decode the card mode
// - I/O modes use I/O strobes, else memory
`ifndef ECNPM_CFG_SVH
`define ECNPM_CFG_SVH
// Top nibble of each chip-select space
`define ECNPM_SPACE_CS3    4'h4
`define ECNPM_SPACE_CS4    4'h5
`define ECNPM_SPACE_CS5    4'h6
// Card mode field position inside the address
`define ECNPM_MODE_MSB     23
`define ECNPM_MODE_LSB     21
// Card mode codes
`define ECNPM_MODE_ATTR    3'h0
`define ECNPM_MODE_COMMON  3'h2
`define ECNPM_MODE_IO      3'h4
`define ECNPM_MODE_IDE     3'h6
`define ECNPM_MODE_ALT_IDE 3'h7
// Chip select 0 defaults after reset
`define ECNPM_CS0_BYTE_SEL 1'h1
`define ECNPM_CS0_DBW_16   2'h1
`define ECNPM_CS0_CS_CTRL  1'h1
`endif

// ==== rtl/ecnpm_mux.sv ====
/*
 * Pin multiplexer of the external bus interface for two card slots
 * on chip selects 4/5 and a flash device on chip select 3.
 * Assumes the memory controller strobes and chip selects arrive
 * synchronous to clk_in; all outputs except external_wait_n_out are registered once.
 */
`timescale 1ns/1ns
`include "ecnpm_cfg.svh"
module ecnpm_mux #(
   parameter int ADDR_W = 32   // System bus address width
) (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               srst_in,
   // Assignment bits of the chip select assignment register
   input  wire logic               card_slot0_enable_in,
   input  wire logic               card_slot1_enable_in,
   input  wire logic               nand_enable_in,
   // Current transfer from the memory controller
   input  wire logic               xfer_active_in,
   input  wire logic [ADDR_W-1:0]  xfer_addr_in,
   input  wire logic               xfer_read_in,
   // Static memory controller strobes, active low, and address 25
   input  wire logic [7:0]         ctl_cs_n_in,
   input  wire logic               read_strobe_n_in,
   input  wire logic               write_strobe0_n_in,
   input  wire logic               write_byte_select1_n_in,
   input  wire logic               write_byte_select3_n_in,
   input  wire logic               ctl_a25_in,
   // Card wait from the slot, active low
   input  wire logic               card_wait_n_in,
   // Wait toward the memory controller
   output logic                    external_wait_n_out,
   // Dedicated and shared pins
   output logic                    chip_select_three_n_out,
   output logic                    chip_select_four_n_out,
   output logic                    chip_select_five_n_out,
   output logic                    chip_select_six_n_out,
   output logic                    chip_select_seven_n_out,
   output logic                    pin_rd_oe_n_out,
   output logic                    pin_wr0_we_n_out,
   output logic                    pin_bs1_ior_n_out,
   output logic                    pin_bs3_iow_n_out,
   output logic                    pin_a25_rnw_out,
   // Status of the current card transfer
   output ecnpm_pkg::ecnpm_mode_t  card_mode_out,
   output logic                    card_access_out,
   // Chip select 0 boot configuration
   output logic                    cs0_byte_select_out,
   output logic [1:0]              cs0_bus_width_out,
   output logic                    cs0_cs_strobes_out
);
   import ecnpm_pkg::*;

   // Refuse address widths that cannot hold the space nibble at 31:28
   if (ADDR_W < 32) begin : g_bad_width
      $error("ecnpm_mux: ADDR_W must be at least 32");
   end

   //////////////////////////////////////////////////////////////////
   // Address decode
   //////////////////////////////////////////////////////////////////
   logic [3:0]   space;        // Top nibble of the address
   logic         card_hit;     // Access to an enabled card slot
   logic         nand_hit;     // Access to the enabled flash space
   ecnpm_mode_t  mode;         // Card mode field
   logic         io_mode;      // I/O or true IDE style strobes
   logic         ide_mode;     // True IDE or its alternate

   // Classify the transfer from its address
   always_comb begin
      space    = xfer_addr_in[31:28];
      card_hit = xfer_active_in &&
                 ((space == `ECNPM_SPACE_CS4 && card_slot0_enable_in) ||
                  (space == `ECNPM_SPACE_CS5 && card_slot1_enable_in));
      nand_hit = xfer_active_in && nand_enable_in &&
                 (space == `ECNPM_SPACE_CS3);
      mode     = xfer_addr_in[`ECNPM_MODE_MSB:`ECNPM_MODE_LSB];
      ide_mode = (mode == `ECNPM_MODE_IDE) ||
                 (mode == `ECNPM_MODE_ALT_IDE);
      io_mode  = (mode == `ECNPM_MODE_IO) || ide_mode;
   end

   // Card wait passes straight to the controller during card access
   always_comb begin
      external_wait_n_out = card_hit ? card_wait_n_in : 1'h1;
   end

   //////////////////////////////////////////////////////////////////
   // Transfer tracker and held direction
   //////////////////////////////////////////////////////////////////
   ecnpm_xfer_e xfer_r, xfer_nxt;  // Class of the running transfer
   logic        rnw_r, rnw_nxt;    // Card direction, held per transfer

   // Catch direction at the first cycle of each card transfer
   always_comb begin
      xfer_nxt = xfer_r;
      rnw_nxt  = rnw_r;
      unique case (xfer_r)
         ECNPM_XF_IDLE: begin
            if (card_hit) begin
               xfer_nxt = ECNPM_XF_CARD;
               rnw_nxt  = xfer_read_in;
            end else if (xfer_active_in) begin
               xfer_nxt = ECNPM_XF_OTHER;
            end
         end
         ECNPM_XF_CARD: begin
            // Direction frozen until the transfer ends
            if (!xfer_active_in) begin
               xfer_nxt = ECNPM_XF_IDLE;
            end
         end
         ECNPM_XF_OTHER: begin
            if (!xfer_active_in) begin
               xfer_nxt = ECNPM_XF_IDLE;
            end
         end
      endcase
   end

   // Register tracker state
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         xfer_r <= ECNPM_XF_IDLE;
         rnw_r  <= 1'h1;
      end else begin
         xfer_r <= xfer_nxt;
         rnw_r  <= rnw_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Pin multiplexing
   //////////////////////////////////////////////////////////////////
   logic        cs3_r, cs3_nxt;   // Chip select three pin
   logic        cs4_r, cs4_nxt;   // Chip select four / card select 0
   logic        cs5_r, cs5_nxt;   // Chip select five / card select 1
   logic        cs6_r, cs6_nxt;   // Chip select six / flash read
   logic        cs7_r, cs7_nxt;   // Chip select seven / flash write
   logic        rd_r, rd_nxt;     // Read strobe / card output enable
   logic        wr0_r, wr0_nxt;   // Write strobe / card write enable
   logic        bs1_r, bs1_nxt;   // Byte select 1 / card I/O read
   logic        bs3_r, bs3_nxt;   // Byte select 3 / card I/O write
   logic        a25_r, a25_nxt;   // Address 25 / card direction
   logic        card_r, card_nxt; // Card access flag
   ecnpm_mode_t mode_r, mode_nxt; // Card mode of last card access
   logic        fl_oe, fl_we;     // Flash strobes before the pin mux
   logic        rnw_now;          // Direction valid from first cycle

   // Compute next pin values
   always_comb begin
      rnw_now  = (xfer_r == ECNPM_XF_CARD) ? rnw_r : xfer_read_in;
      // Flash strobes only with chip select three inside its space
      fl_oe    = (nand_hit && !ctl_cs_n_in[3]) ?
                 read_strobe_n_in : 1'h1;
      // Same strobes for command, address and data words
      fl_we    = (nand_hit && !ctl_cs_n_in[3]) ?
                 write_strobe0_n_in : 1'h1;
      cs3_nxt  = ctl_cs_n_in[3];
      // Card select carries the chip select waveform unchanged
      cs4_nxt  = ctl_cs_n_in[4];
      cs5_nxt  = ctl_cs_n_in[5];
      cs6_nxt  = nand_enable_in ? fl_oe : ctl_cs_n_in[6];
      cs7_nxt  = nand_enable_in ? fl_we : ctl_cs_n_in[7];
      card_nxt = card_hit;
      mode_nxt = card_hit ? mode : mode_r;
      if (card_hit) begin
         // Card strobes by mode
         if (io_mode) begin
            rd_nxt  = ide_mode ? 1'h0 : 1'h1;
            wr0_nxt = 1'h1;
            bs1_nxt = read_strobe_n_in;
            bs3_nxt = write_strobe0_n_in;
         end else begin
            rd_nxt  = read_strobe_n_in;
            wr0_nxt = write_strobe0_n_in;
            bs1_nxt = 1'h1;
            bs3_nxt = 1'h1;
         end
         a25_nxt = rnw_now;
      end else begin
         // Normal bus functions
         rd_nxt  = read_strobe_n_in;
         wr0_nxt = write_strobe0_n_in;
         bs1_nxt = write_byte_select1_n_in;
         bs3_nxt = write_byte_select3_n_in;
         a25_nxt = ctl_a25_in;
      end
   end

   // Register pins; idle levels under reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cs3_r  <= 1'h1;
         cs4_r  <= 1'h1;
         cs5_r  <= 1'h1;
         cs6_r  <= 1'h1;
         cs7_r  <= 1'h1;
         rd_r   <= 1'h1;
         wr0_r  <= 1'h1;
         bs1_r  <= 1'h1;
         bs3_r  <= 1'h1;
         a25_r  <= 1'h0;
         card_r <= 1'h0;
         mode_r <= `ECNPM_MODE_ATTR;
      end else begin
         cs3_r  <= cs3_nxt;
         cs4_r  <= cs4_nxt;
         cs5_r  <= cs5_nxt;
         cs6_r  <= cs6_nxt;
         cs7_r  <= cs7_nxt;
         rd_r   <= rd_nxt;
         wr0_r  <= wr0_nxt;
         bs1_r  <= bs1_nxt;
         bs3_r  <= bs3_nxt;
         a25_r  <= a25_nxt;
         card_r <= card_nxt;
         mode_r <= mode_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Chip select 0 boot configuration
   //////////////////////////////////////////////////////////////////
   logic       bsel_r;   // Byte select mode
   logic [1:0] dbw_r;    // Data bus width code
   logic       csc_r;    // Strobes controlled by chip select

   // Loaded by reset, steady afterwards
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         bsel_r <= `ECNPM_CS0_BYTE_SEL;
         dbw_r  <= `ECNPM_CS0_DBW_16;
         csc_r  <= `ECNPM_CS0_CS_CTRL;
      end
   end

   // Drive outputs from registers
   assign chip_select_three_n_out = cs3_r;
   assign chip_select_four_n_out  = cs4_r;
   assign chip_select_five_n_out  = cs5_r;
   assign chip_select_six_n_out   = cs6_r;
   assign chip_select_seven_n_out = cs7_r;
   assign pin_rd_oe_n_out         = rd_r;
   assign pin_wr0_we_n_out        = wr0_r;
   assign pin_bs1_ior_n_out       = bs1_r;
   assign pin_bs3_iow_n_out       = bs3_r;
   assign pin_a25_rnw_out         = a25_r;
   assign card_access_out         = card_r;
   assign card_mode_out           = mode_r;
   assign cs0_byte_select_out     = bsel_r;
   assign cs0_bus_width_out       = dbw_r;
   assign cs0_cs_strobes_out      = csc_r;

   //////////////////////////////////////////////////////////////////
   // Checks
   //////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_cs4_mirror: assert property (
      ##1 chip_select_four_n_out == $past(ctl_cs_n_in[4]))
      else $error("card select 0 lost chip select four timing");
   a_cs4_timing: assert property (
      $fell(ctl_cs_n_in[4]) |=> $fell(chip_select_four_n_out))
      else $error("card select 0 edge misplaced");
   a_card_strobes: assert property (
      card_hit && !io_mode |=> pin_rd_oe_n_out == $past(read_strobe_n_in)
                              && pin_bs1_ior_n_out)
      else $error("memory mode strobes wrong");
   a_io_strobes: assert property (
      card_hit && io_mode |=> pin_bs1_ior_n_out == $past(read_strobe_n_in)
                             && pin_wr0_we_n_out)
      else $error("I/O mode strobes wrong");
   a_rnw_hold: assert property (
      xfer_r == ECNPM_XF_CARD && xfer_active_in
         |=> $stable(pin_a25_rnw_out))
      else $error("card direction changed mid transfer");
   a_wait_pass: assert property (
      card_hit |-> external_wait_n_out == card_wait_n_in)
      else $error("card wait not passed");
   a_flash_drop: assert property (
      nand_enable_in && !nand_hit |=> chip_select_six_n_out
                                     && chip_select_seven_n_out)
      else $error("flash strobes outside their space");
   a_flash_read: assert property (
      nand_hit && !ctl_cs_n_in[3] |=>
         chip_select_six_n_out == $past(read_strobe_n_in))
      else $error("flash read strobe not steered");
   a_cs6_plain: assert property (
      !nand_enable_in |=> chip_select_six_n_out == $past(ctl_cs_n_in[6]))
      else $error("chip select six lost");
   a_normal_bus: assert property (
      !card_hit |=> pin_a25_rnw_out == $past(ctl_a25_in) && !card_access_out)
      else $error("normal transfer altered");
   a_boot_cfg: assert property (
      cs0_bus_width_out == `ECNPM_CS0_DBW_16 && cs0_byte_select_out
         && cs0_cs_strobes_out)
      else $error("chip select 0 boot defaults lost");

   c_card_read:  cover property (card_hit && xfer_read_in ##1 card_hit);
   c_card_ide:   cover property (card_hit && ide_mode);
   c_flash_wr:   cover property (nand_hit && !write_strobe0_n_in);
   c_card_wait:  cover property (card_hit && !card_wait_n_in [*2]);

endmodule : ecnpm_mux

// ==== rtl/ecnpm_pkg.sv ====
/*
 * Types of the card and flash pin multiplexer.
 * Assumes nothing beyond the constants header.
 */
package ecnpm_pkg;
   // Class of the transfer currently on the bus
   typedef enum logic [2:0] {
      ECNPM_XF_IDLE  = 3'h1,
      ECNPM_XF_CARD  = 3'h2,
      ECNPM_XF_OTHER = 3'h4
   } ecnpm_xfer_e;
   // Card mode field as decoded from the address
   typedef logic [2:0] ecnpm_mode_t;
endpackage : ecnpm_pkg
